// ==== src/angle_sensor_pkg.sv ====
// Shared constants and types for the angle sensor serial port and its filter.
// Assumes a 40 MHz system clock and a front-end sampled at 1 MHz.
package angle_sensor_pkg;

  localparam int SYS_CLK_HZ         = 40_000_000;
  localparam int SAMPLE_RATE_HZ     = 1_000_000;
  localparam int SAMPLE_DIV         = SYS_CLK_HZ / SAMPLE_RATE_HZ;
  localparam int SAMPLE_CNT_W       = 6;

  localparam real FILTER_TAU_FACTOR = 0.38;
  localparam real FILTER_CUTOFF_HZ  = 90.0;
  localparam int  TAU_SAMPLES       =
    int'(FILTER_TAU_FACTOR / FILTER_CUTOFF_HZ * SAMPLE_RATE_HZ);
  localparam int  TAU_SHIFT         = $clog2(TAU_SAMPLES);
  localparam int  FRAC_BITS         = 2 * TAU_SHIFT;
  localparam int  GAIN1_SHIFT       = FRAC_BITS - TAU_SHIFT + 1;
  localparam int  GAIN2_SHIFT       = FRAC_BITS - 2 * TAU_SHIFT;

  localparam int NVM_WAIT_TIME_MS    = 20;
  localparam int NVM_WAIT_CYCLES_DEF = NVM_WAIT_TIME_MS * (SYS_CLK_HZ / 1000);
  localparam int NVM_TIMER_W         = 20;

  localparam int ANGLE_W     = 16;
  localparam int FIELD_W     = 8;
  localparam int FRAME_BITS  = 16;
  localparam int LAST_BIT    = FRAME_BITS - 1;
  localparam int RX_CNT_W    = 5;
  localparam int FIFO_DEPTH  = 8;
  localparam int NUM_REGS    = 32;

  localparam logic [ANGLE_W-1:0] ANGLE_MASK = 16'hff00;
  localparam logic [7:0]         REG_PAD    = 8'h00;

  localparam logic [2:0] OPC_READ  = 3'h2;
  localparam logic [2:0] OPC_WRITE = 3'h4;

  localparam logic [4:0] REG_ZERO_LO = 5'h00;
  localparam logic [4:0] REG_ZERO_HI = 5'h01;
  localparam logic [4:0] REG_THRESH  = 5'h06;
  localparam logic [4:0] REG_DIR     = 5'h09;
  localparam logic [4:0] REG_FLAGS   = 5'h1b;

  localparam logic [7:0] THRESH_RESET   = 8'h1c;
  localparam int         LOW_THR_MSB    = 7;
  localparam int         LOW_THR_LSB    = 5;
  localparam int         HIGH_THR_MSB   = 4;
  localparam int         HIGH_THR_LSB   = 2;
  localparam int         DIR_BIT        = 7;
  localparam int         FLAG_HIGH_BIT  = 7;
  localparam int         FLAG_LOW_BIT   = 6;
  localparam int         THR_LEVEL_SHIFT = 5;

  typedef struct packed {
    logic [2:0] opcode;
    logic [4:0] addr;
    logic [7:0] data;
  } cmd_frame_t;

  typedef enum logic [1:0] {
    EX_IDLE = 2'b01,
    EX_NVM  = 2'b10
  } ex_state_t;

endpackage : angle_sensor_pkg

// ==== src/cmd_fifo.sv ====
// Synchronous FIFO in flip-flops with valid/ready handshakes on both sides.
// Assumes both sides run on the same clock.
`timescale 1ns/10ps
module cmd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

endmodule : cmd_fifo

// ==== src/angle_filter.sv ====
// Second-order tracking filter for the wrapped angle stream.
// Assumes one input sample per in_valid_i strobe on the system clock.
`timescale 1ns/10ps
module angle_filter (
  input  wire logic                                 sys_clk_i,
  input  wire logic                                 reset_n_i,
  input  wire logic                                 in_valid_i,
  input  wire logic [angle_sensor_pkg::ANGLE_W-1:0] in_angle_i,
  output logic [angle_sensor_pkg::ANGLE_W-1:0]      out_angle_o
);
  import angle_sensor_pkg::*;

  localparam int ACC_W = ANGLE_W + FRAC_BITS;

  logic [ACC_W-1:0]        pos;
  logic signed [ACC_W-1:0] vel;
  logic [ANGLE_W-1:0]      err;
  logic signed [ACC_W-1:0] err_ext;

  // The difference is taken modulo a full turn so the loop tracks across the wrap.
  assign err     = in_angle_i - pos[ACC_W-1 -: ANGLE_W];
  assign err_ext = {{(ACC_W-ANGLE_W){err[ANGLE_W-1]}}, err};

  // A critically damped type-2 loop has exactly the lead-lag response wanted and
  // follows a constant speed with no steady error, so no latency remains.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pos <= '0;
      vel <= '0;
    end
    else if (in_valid_i)
    begin
      pos <= pos + vel + (err_ext <<< GAIN1_SHIFT);
      vel <= vel + (err_ext <<< GAIN2_SHIFT);
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      out_angle_o <= '0;
    end
    else
    begin
      out_angle_o <= pos[ACC_W-1 -: ANGLE_W];
    end
  end

  chk_filter_settled_hold: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (in_valid_i && err == '0 && vel == '0) |=> ##1 (out_angle_o == $past(out_angle_o, 1))
  ) else $error("Settled filter output moved.");

endmodule : angle_filter

// ==== src/angle_sensor_spi_port.sv ====
// Serial target port, configuration store, angle conditioning and field flags.
// Assumes a host drives sclk_i, cs_n_i and mosi_i; sclk_i stands still between frames.
`timescale 1ns/10ps
module angle_sensor_spi_port #(
  parameter int NVM_WAIT_CYCLES = angle_sensor_pkg::NVM_WAIT_CYCLES_DEF
) (
  input  wire logic                                 sys_clk_i,
  input  wire logic                                 reset_n_i,
  input  wire logic                                 sclk_i,
  input  wire logic                                 cs_n_i,
  input  wire logic                                 mosi_i,
  input  wire logic [angle_sensor_pkg::ANGLE_W-1:0] raw_angle_i,
  input  wire logic [angle_sensor_pkg::FIELD_W-1:0] field_strength_i,
  output logic                                      miso_o,
  output logic                                      miso_oe_o,
  output logic                                      miso_pd_o,
  output logic                                      field_low_flag_o,
  output logic                                      field_high_flag_o,
  output logic                                      nvm_busy_o
);
  import angle_sensor_pkg::*;

  localparam int SAMPLE_GAP = SAMPLE_DIV;

  function automatic logic [FIELD_W-1:0] thr_level(input logic [2:0] thr);
    thr_level = FIELD_W'(thr) << THR_LEVEL_SHIFT;
  endfunction : thr_level

  // Link side, clocked by the host's serial clock.
  logic [RX_CNT_W-1:0] rx_cnt;
  logic [LAST_BIT:0]   rx_shift;
  cmd_frame_t          rx_word;
  logic                rx_tgl;
  logic                miso_q;
  logic                tx_started;

  // System side.
  logic                cs_s1;
  logic                cs_s2;
  logic                tgl_s1;
  logic                tgl_s2;
  logic                tgl_d;
  logic                frame_evt;
  logic                push_valid;
  cmd_frame_t          push_frame;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  cmd_frame_t          head;
  logic                pop;
  ex_state_t           state;
  logic [NVM_TIMER_W-1:0] nvm_timer;
  logic                nvm_done;
  cmd_frame_t          pend;
  logic [7:0]          cfg_regs [NUM_REGS];
  logic                resp_is_reg;
  logic [4:0]          resp_addr;
  logic [7:0]          flags_byte;
  logic [7:0]          reg_rd;
  logic [LAST_BIT:0]   tx_word;
  logic [SAMPLE_CNT_W-1:0] sample_cnt;
  logic                sample_tick;
  logic [ANGLE_W-1:0]  filt_angle;
  logic [ANGLE_W-1:0]  angle_out;
  logic [ANGLE_W-1:0]  zero_offset;
  logic                dir_ccw;
  logic [FIELD_W-1:0]  low_level;
  logic [FIELD_W-1:0]  high_level;

  // Each rising edge samples one bit; the count restarts whenever select is high.
  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      rx_cnt <= '0;
    end
    else if (rx_cnt != RX_CNT_W'(FRAME_BITS))
    begin
      rx_cnt <= rx_cnt + 1'b1;
    end
  end

  always_ff @(posedge sclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rx_shift <= '0;
    end
    else if (!cs_n_i)
    begin
      rx_shift <= {rx_shift[LAST_BIT-1:0], mosi_i};
    end
  end

  // Only a complete sixteenth bit produces a command; shorter frames leave the selected answer (angle or register) unchanged.
  always_ff @(posedge sclk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rx_word <= '0;
      rx_tgl  <= 1'b0;
    end
    else if (!cs_n_i && rx_cnt == RX_CNT_W'(LAST_BIT))
    begin
      rx_word <= {rx_shift[LAST_BIT-1:0], mosi_i};
      rx_tgl  <= ~rx_tgl;
    end
  end

  // The bit index follows the rising edges already seen, so a mode 3 frame,
  // whose first falling edge precedes any sample, launches the MSB there while a
  // mode 0 frame has already shown it since select fell.
  always_ff @(negedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      miso_q     <= 1'b0;
      tx_started <= 1'b0;
    end
    else
    begin
      tx_started <= 1'b1;
      miso_q     <= (rx_cnt < RX_CNT_W'(FRAME_BITS)) ?
                    tx_word[LAST_BIT - int'(rx_cnt)] : 1'b0;
    end
  end

  // Before the first falling edge the MSB must already stand for mode 0.
  assign miso_o    = tx_started ? miso_q : tx_word[LAST_BIT];
  assign miso_oe_o = !cs_n_i;
  assign miso_pd_o = cs_n_i;

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_d  <= 1'b0;
    end
    else
    begin
      cs_s1  <= cs_n_i;
      cs_s2  <= cs_s1;
      tgl_s1 <= rx_tgl;
      tgl_s2 <= tgl_s1;
      tgl_d  <= tgl_s2;
    end
  end

  assign frame_evt = tgl_s2 ^ tgl_d;

  // The received word is stable for a whole frame after its toggle, so it is
  // read here without further synchronising.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      push_valid <= 1'b0;
      push_frame <= '0;
    end
    else if (frame_evt)
    begin
      push_valid <= 1'b1;
      push_frame <= rx_word;
    end
    else if (fifo_in_ready)
    begin
      push_valid <= 1'b0;
    end
  end

  cmd_fifo #(
    .WIDTH ($bits(cmd_frame_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_frame),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (state == EX_IDLE),
    .out_data_o  (head)
  );

  assign pop      = fifo_out_valid && (state == EX_IDLE);
  assign nvm_done = (nvm_timer == NVM_TIMER_W'(NVM_WAIT_CYCLES - 1));

  // Commands stall in the queue while the memory is being written.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state <= EX_IDLE;
    end
    else
    begin
      case (state)
        EX_IDLE:
        begin
          if (pop && head.opcode == OPC_WRITE)
          begin
            state <= EX_NVM;
          end
        end
        EX_NVM:
        begin
          if (nvm_done)
          begin
            state <= EX_IDLE;
          end
        end
        default:
        begin
          state <= EX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      nvm_timer <= '0;
      pend      <= '0;
    end
    else
    begin
      nvm_timer <= (state == EX_NVM) ? nvm_timer + 1'b1 : '0;
      if (pop && head.opcode == OPC_WRITE)
      begin
        pend <= head;
      end
    end
  end

  // The register keeps its old value until the write time has passed.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        cfg_regs[i] <= (5'(i) == REG_THRESH) ? THRESH_RESET : 8'h00;
      end
    end
    else if (state == EX_NVM && nvm_done && pend.addr != REG_FLAGS)
    begin
      cfg_regs[pend.addr] <= pend.data;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      resp_is_reg <= 1'b0;
      resp_addr   <= '0;
    end
    else if (pop)
    begin
      resp_is_reg <= (head.opcode == OPC_READ) || (head.opcode == OPC_WRITE);
      resp_addr   <= head.addr;
    end
  end

  always_comb
  begin
    flags_byte                = 8'h00;
    flags_byte[FLAG_HIGH_BIT] = field_high_flag_o;
    flags_byte[FLAG_LOW_BIT]  = field_low_flag_o;
  end

  assign reg_rd = (resp_addr == REG_FLAGS) ? flags_byte : cfg_regs[resp_addr];

  // The answer is frozen while the synchronised select cs_s2 is low, which starts two system clocks after select falls.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tx_word <= '0;
    end
    else if (cs_s2)
    begin
      tx_word <= resp_is_reg ? {reg_rd, REG_PAD} : (angle_out & ANGLE_MASK);
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sample_cnt  <= '0;
      sample_tick <= 1'b0;
    end
    else
    begin
      sample_tick <= (sample_cnt == SAMPLE_CNT_W'(SAMPLE_DIV - 1));
      sample_cnt  <= (sample_cnt == SAMPLE_CNT_W'(SAMPLE_DIV - 1)) ? '0 : sample_cnt + 1'b1;
    end
  end

  angle_filter u_angle_filter (
    .sys_clk_i   (sys_clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (sample_tick),
    .in_angle_i  (raw_angle_i),
    .out_angle_o (filt_angle)
  );

  assign zero_offset = {cfg_regs[REG_ZERO_HI], cfg_regs[REG_ZERO_LO]};
  assign dir_ccw     = cfg_regs[REG_DIR][DIR_BIT];

  // Negating the filtered angle reverses its direction modulo a turn; the zero position is then added.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      angle_out <= '0;
    end
    else
    begin
      angle_out <= (dir_ccw ? ANGLE_W'(-filt_angle) : filt_angle) + zero_offset;
    end
  end

  assign low_level  = thr_level(cfg_regs[REG_THRESH][LOW_THR_MSB:LOW_THR_LSB]);
  assign high_level = thr_level(cfg_regs[REG_THRESH][HIGH_THR_MSB:HIGH_THR_LSB]);

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      field_low_flag_o  <= 1'b0;
      field_high_flag_o <= 1'b0;
      nvm_busy_o        <= 1'b0;
    end
    else
    begin
      field_low_flag_o  <= (field_strength_i < low_level);
      field_high_flag_o <= (field_strength_i > high_level);
      nvm_busy_o        <= (state == EX_NVM);
    end
  end

  sequence s_write_taken;
    pop && head.opcode == OPC_WRITE && head.addr != REG_FLAGS;
  endsequence

  sequence s_write_done;
    state == EX_NVM && nvm_done;
  endsequence

  chk_low_flag_level: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (field_strength_i < low_level) |=> field_low_flag_o
  ) else $error("Low-field flag not raised below threshold.");

  chk_high_flag_level: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    !(field_strength_i > high_level) |=> !field_high_flag_o
  ) else $error("High-field flag raised without strong field.");

  chk_sample_rate: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    sample_tick |=> !sample_tick ##(SAMPLE_GAP - 1) sample_tick
  ) else $error("Sample strobe spacing wrong.");

  chk_default_direction: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (!dir_ccw && zero_offset == '0) [*2] |-> angle_out == $past(filt_angle)
  ) else $error("Unprogrammed angle differs from filtered angle.");

  chk_miso_launch: assert property (
    @(posedge sclk_i) disable iff (cs_n_i || !reset_n_i)
    (tx_started && rx_cnt < RX_CNT_W'(FRAME_BITS)) |->
      miso_q == tx_word[LAST_BIT - int'(rx_cnt)]
  ) else $error("Launched bit does not match frame position.");

  chk_miso_release: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    miso_oe_o != miso_pd_o
  ) else $error("Pull-down and drive overlap.");

  chk_read_response: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (pop && head.opcode == OPC_READ) |=> resp_is_reg && resp_addr == $past(head.addr)
  ) else $error("Read request did not select register answer.");

  chk_write_commit: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    s_write_taken ##1 (!nvm_done) [*2] |->
      state == EX_NVM && nvm_busy_o && resp_addr == pend.addr
  ) else $error("Write did not enter memory update.");

  chk_write_value: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    s_write_done |=> cfg_regs[$past(pend.addr)] == $past(pend.data) || $past(pend.addr) == REG_FLAGS
  ) else $error("Written value not stored after update.");

  chk_angle_zero_pad: assert property (
    @(posedge sys_clk_i) disable iff (!reset_n_i)
    (cs_s2 && !resp_is_reg) |=> tx_word[7:0] == 8'h00 && tx_word[15:8] == $past(angle_out[15:8])
  ) else $error("Angle answer not padded with zeros.");

endmodule : angle_sensor_spi_port

// ==== verification/spi_host_model.sv ====
// Host side model of the serial port: drives select, clock and data one frame at a time.
// Assumes the bench resolves the data-out line with its pull-down and feeds it to miso_i.
`timescale 1ns/10ps
module spi_host_model (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // Half period of 3 ns; the clock stands still between frames at the idle level of the mode.
  task automatic xfer(input logic mode3, input logic [15:0] tx, output logic [15:0] rx);
    sclk_o = mode3;
    #20;
    cs_n_o = 1'b0;
    mosi_o = tx[15];
    #12;
    for (int i = 15; i >= 0; i--)
    begin
      sclk_o = 1'b0;
      mosi_o = tx[i];
      #3;
      sclk_o = 1'b1;
      rx[i] = miso_i;
      #3;
    end
    sclk_o = mode3;
    #6;
    cs_n_o = 1'b1;
    // The data-out pin has a pull-down, so a released line reads low.
    mosi_o = 1'b0;
    #800;
  endtask : xfer
endmodule : spi_host_model

// ==== verification/angle_sensor_spi_port_tb_top.sv ====
// Self-checking bench of the serial port: register reads and writes, flags and angle frames.
// Assumes the host model drives the link; the raw angle is held at zero so the filter stays put.
`timescale 1ns/10ps
module angle_sensor_spi_port_tb_top;
  import angle_sensor_pkg::*;
  localparam int NVM_WAIT = 50;
  logic        sys_clk;
  logic        reset_n;
  logic [7:0]  strength;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic        miso_pd;
  logic        low_flag;
  logic        high_flag;
  logic        nvm_busy;
  logic        mode3;
  logic [15:0] rx;
  int          n_fail;
  int          checked;
  int          cycles;
  logic [4:0]  addrs [4] = '{REG_ZERO_LO, REG_ZERO_HI, REG_THRESH, REG_DIR};
  logic [7:0]  defs [4] = '{8'h00, 8'h00, 8'h1c, 8'h00};
  logic [7:0]  levels [4] = '{8'h5f, 8'h60, 8'ha0, 8'ha1};
  logic [3:0]  low_exp = 4'h1;
  logic [3:0]  high_exp = 4'h8;
  wire         miso_line = miso_oe ? miso : 1'b0;

  angle_sensor_spi_port #(.NVM_WAIT_CYCLES(NVM_WAIT)) angle_sensor_spi_port_i (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .sclk_i(sclk), .cs_n_i(cs_n),
    .mosi_i(mosi), .raw_angle_i(16'h0000), .field_strength_i(strength),
    .miso_o(miso), .miso_oe_o(miso_oe), .miso_pd_o(miso_pd),
    .field_low_flag_o(low_flag), .field_high_flag_o(high_flag), .nvm_busy_o(nvm_busy)
  );
  spi_host_model spi_host_model_i (
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_line)
  );

  always #12.5 sys_clk = ~sys_clk;

  task automatic compare(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : compare

  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end

  always @(negedge cs_n)
  begin
    #1;
    compare("enable in frame", 16'h0001, {15'h0000, miso_oe});
    compare("pull-down in frame", 16'h0000, {15'h0000, miso_pd});
  end

  // Each frame swaps between mode 0 and mode 3; every answer that read_reg checks arrives in a mode 3 frame.
  task automatic frame(input logic [15:0] tx);
    @(negedge sys_clk);
    mode3 = ~mode3;
    spi_host_model_i.xfer(mode3, tx, rx);
    compare("enable idle", 16'h0000, {15'h0000, miso_oe});
    compare("pull-down idle", 16'h0001, {15'h0000, miso_pd});
  endtask : frame

  task automatic read_reg(input logic [4:0] addr, input logic [7:0] val);
    frame({OPC_READ, addr, 8'h00});
    frame(16'h0000);
    compare("register read", {val, 8'h00}, rx);
  endtask : read_reg

  task automatic nvm_wait();
    repeat (NVM_WAIT + 30) @(negedge sys_clk);
  endtask : nvm_wait

  initial
  begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    strength = 8'h80;
    mode3 = 1'b1;
    n_fail = 0;
    checked = 0;
    cycles = 0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (int i = 0; i < 4; i++)
      read_reg(addrs[i], defs[i]);
    $display("test register defaults done");
    frame({OPC_WRITE, REG_ZERO_HI, 8'hf1});
    repeat (15) @(negedge sys_clk);
    compare("memory busy", 16'h0001, {15'h0000, nvm_busy});
    nvm_wait();
    compare("memory idle", 16'h0000, {15'h0000, nvm_busy});
    frame(16'h0000);
    compare("write echo", 16'hf100, rx);
    frame(16'h0000);
    compare("angle with zero offset", 16'hf100, rx);
    $display("test write and angle done");
    frame({OPC_WRITE, REG_ZERO_LO, 8'h5a});
    frame(16'h0000);
    compare("early answer", 16'h0000, rx);
    nvm_wait();
    frame(16'h0000);
    compare("angle after write", 16'hf100, rx);
    read_reg(REG_ZERO_LO, 8'h5a);
    $display("test early readback done");
    // Low threshold code 3 and high code 5 give levels 0x60 and 0xa0.
    frame({OPC_WRITE, REG_THRESH, 8'h74});
    nvm_wait();
    for (int i = 0; i < 4; i++)
    begin
      strength = levels[i];
      repeat (3) @(negedge sys_clk);
      compare("low flag", {15'h0000, low_exp[i]}, {15'h0000, low_flag});
      compare("high flag", {15'h0000, high_exp[i]}, {15'h0000, high_flag});
    end
    strength = 8'h5f;
    frame({OPC_WRITE, REG_FLAGS, 8'hff});
    nvm_wait();
    read_reg(REG_FLAGS, 8'h40);
    $display("test field flags done");
    complete_run();
  end
endmodule : angle_sensor_spi_port_tb_top
